// *** rtl/fpdc_defines.svh ***
// Constants for the fast page DRAM controller
`ifndef FPDC_DEFINES_SVH
`define FPDC_DEFINES_SVH
`define FPDC_CLK_MHZ        20
`define FPDC_ADDR_W         11
`define FPDC_ROW_W          11
`define FPDC_COL_W          11
`define FPDC_WORDS          4194304
`define FPDC_REF_ROWS       1024
`define FPDC_REF_MS_X10     164
`define FPDC_REF_SELF_MS    128
`define FPDC_PWRUP_US       200
`define FPDC_INIT_CYCLES    8
`define FPDC_PWRUP_CYC      ((`FPDC_PWRUP_US * `FPDC_CLK_MHZ))
`define FPDC_REF_GAP_CYC    ((`FPDC_REF_MS_X10 * 100 * `FPDC_CLK_MHZ) / `FPDC_REF_ROWS)
`define FPDC_REF_GAP_SELF   ((`FPDC_REF_SELF_MS * 1000 * `FPDC_CLK_MHZ) / `FPDC_REF_ROWS)
`define FPDC_RAS_PRE_CYC    1
`define FPDC_STEP_CYC       1
`define FPDC_SYNC_WAIT      2
`endif

// *** rtl/fpdc_pkg.sv ***
// Types for the fast page DRAM controller
package fpdc_pkg;
  // Request command codes
  typedef enum logic [1:0] {
    FPDC_CMD_READ  = 2'b00,
    FPDC_CMD_WRITE = 2'b01,
    FPDC_CMD_RMW   = 2'b10
  } fpdc_cmd_t;
  // One user request
  typedef struct packed {
    fpdc_cmd_t   cmd;
    logic [10:0] row;
    logic [10:0] col;
    logic        wdata;
  } fpdc_req_t;
  // Pins driven toward the memory
  typedef struct packed {
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        din;
    logic [10:0] addr;
  } fpdc_pins_t;
endpackage : fpdc_pkg

// *** rtl/fpdc_ctrl.sv ***
// Host-side controller driving a 4M x 1 fast page DRAM
`timescale 1ns/1ns
`include "fpdc_defines.svh"
`default_nettype none
module fpdc_ctrl #(
  parameter int unsigned PWRUP_CYC = `FPDC_PWRUP_CYC,
  parameter int unsigned REF_GAP   = `FPDC_REF_GAP_CYC,
  parameter bit          USE_CBR   = 1'b1
) (
  // Clock and reset
  input  wire  logic               clk_i,
  input  wire  logic               rstn_i,
  // User request side
  input  wire  fpdc_pkg::fpdc_req_t req_i,
  input  wire  logic               req_valid_i,
  output logic                     req_ready_o,
  // User read data side
  output fpdc_pkg::fpdc_req_t      unused_dummy_o,
  output logic                     rd_data_o,
  output logic                     rd_valid_o,
  input  wire  logic               rd_ready_i,
  // Status
  output logic                     init_done_o,
  // Memory pins
  output fpdc_pkg::fpdc_pins_t     mem_o,
  input  wire  logic               mem_dout_i
);
  typedef enum logic [3:0] {
    FPDC_S_PWRUP  = 4'h0,
    FPDC_S_IDLE   = 4'h1,
    FPDC_S_ROW    = 4'h2,
    FPDC_S_COL    = 4'h3,
    FPDC_S_SAMPLE = 4'h4,
    FPDC_S_WR     = 4'h5,
    FPDC_S_PRE    = 4'h6,
    FPDC_S_CBR1   = 4'h7,
    FPDC_S_CBR2   = 4'h8,
    FPDC_S_ROR    = 4'h9
  } fpdc_state_t;

  fpdc_state_t          state_q;     // Sequencer state
  fpdc_pkg::fpdc_req_t  cur_q;       // Request in flight
  fpdc_pkg::fpdc_pins_t pins_q;      // Registered pin drive
  logic [31:0]          wait_q;      // Power-up pause counter
  logic [31:0]          ref_cnt_q;   // Refresh interval counter
  logic                 ref_due_q;   // Refresh owed
  logic [3:0]           init_cnt_q;  // Init cycles issued
  logic [9:0]           ref_row_q;   // Row-only refresh pointer
  logic                 dsync1_q;    // Data out sync, stage 1
  logic                 dsync2_q;    // Data out sync, stage 2
  logic                 open_q;      // A page is open
  // Two-entry read buffer
  logic [1:0]           buf_d_q;
  logic [1:0]           buf_cnt_q;
  logic                 buf_wp_q;
  logic                 buf_rp_q;
  logic                 buf_push;
  logic                 buf_full;
  // Synchroniser costs two cycles, so the column strobe stays low until the bit is through
  logic [1:0]           smp_cnt_q;   // Sample wait counter
  logic                 ref_step;    // One refresh is counted this cycle

  assign buf_full       = (buf_cnt_q == 2'h2);
  assign mem_o          = pins_q;
  assign init_done_o    = (init_cnt_q == 4'(`FPDC_INIT_CYCLES));
  assign unused_dummy_o = cur_q;
  // Accept only in idle with init done, no refresh owed and buffer room, for writes as well as reads
  assign req_ready_o    = (state_q == FPDC_S_IDLE) && init_done_o && !ref_due_q && !buf_full;
  assign rd_valid_o     = (buf_cnt_q != 2'h0);
  assign rd_data_o      = buf_d_q[buf_rp_q];
  assign buf_push       = (state_q == FPDC_S_SAMPLE) && (smp_cnt_q == 2'(`FPDC_SYNC_WAIT));
  // Count a refresh once: in CBR2 on the cycle its row strobe is low, in ROR on the cycle before it falls
  assign ref_step       = (state_q == FPDC_S_CBR2 && !pins_q.ras_n) || (state_q == FPDC_S_ROR);

  // Sample wait, restarts on every entry to the sample state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      smp_cnt_q <= 2'h0;
    end else if (state_q == FPDC_S_SAMPLE && !buf_push) begin
      smp_cnt_q <= smp_cnt_q + 2'h1;
    end else begin
      smp_cnt_q <= 2'h0;
    end
  end

  // Data pin is asynchronous, two flops before use
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dsync1_q <= 1'b0;
      dsync2_q <= 1'b0;
    end else begin
      dsync1_q <= mem_dout_i;
      dsync2_q <= dsync1_q;
    end
  end

  // Read buffer, stall by receiver holds words
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buf_d_q   <= 2'h0;
      buf_cnt_q <= 2'h0;
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_d_q[buf_wp_q] <= dsync2_q;
        buf_wp_q          <= ~buf_wp_q;
      end
      if (rd_valid_o && rd_ready_i) begin
        buf_rp_q <= ~buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + 2'(buf_push) - 2'(rd_valid_o && rd_ready_i);
    end
  end

  // Refresh interval timer, sets owed flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_cnt_q <= 32'h0;
      ref_due_q <= 1'b0;
    end else begin
      if (ref_cnt_q >= REF_GAP - 1) begin
        ref_cnt_q <= 32'h0;
        ref_due_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 32'h1;
        // Set wins over clear
        if (ref_step) begin
          ref_due_q <= 1'b0;
        end
      end
    end
  end

  // Power-up pause and init counting
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q     <= 32'h0;
      init_cnt_q <= 4'h0;
    end else begin
      if (state_q == FPDC_S_PWRUP && wait_q < PWRUP_CYC) begin
        wait_q <= wait_q + 32'h1;
      end
      if (!init_done_o && ref_step) begin
        init_cnt_q <= init_cnt_q + 4'h1;
      end
    end
  end

  // Row pointer for row-only refresh
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_row_q <= 10'h0;
    end else if (state_q == FPDC_S_ROR) begin
      ref_row_q <= ref_row_q + 10'h1;
    end
  end

  // Main sequencer, one step per clock (50 ns)
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= FPDC_S_PWRUP;
      cur_q   <= '0;
      open_q  <= 1'b0;
      pins_q  <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, din: 1'b0, addr: 11'h0};
    end else begin
      unique case (state_q)
        FPDC_S_PWRUP: begin
          // Strobes idle through the pause
          pins_q.ras_n <= 1'b1;
          pins_q.cas_n <= 1'b1;
          if (wait_q >= PWRUP_CYC) begin
            state_q <= FPDC_S_PRE;
          end
        end
        FPDC_S_IDLE: begin
          if (!init_done_o || ref_due_q) begin
            // Refresh has priority; close any page first
            pins_q.ras_n <= 1'b1;
            pins_q.cas_n <= 1'b1;
            open_q       <= 1'b0;
            state_q      <= FPDC_S_PRE;
          end else if (req_valid_i && !buf_full) begin
            cur_q <= req_i;
            if (open_q && req_i.row == cur_q.row) begin
              // Page hit: present column only
              pins_q.addr <= req_i.col;
              pins_q.we_n <= (req_i.cmd != fpdc_pkg::FPDC_CMD_WRITE);
              pins_q.din  <= req_i.wdata;
              state_q     <= FPDC_S_COL;
            end else begin
              pins_q.ras_n <= 1'b1;
              pins_q.addr  <= req_i.row;
              open_q       <= 1'b0;
              state_q      <= FPDC_S_ROW;
            end
          end
        end
        FPDC_S_ROW: begin
          // Row latched on falling row strobe
          pins_q.ras_n <= 1'b0;
          open_q       <= 1'b1;
          pins_q.we_n  <= (cur_q.cmd != fpdc_pkg::FPDC_CMD_WRITE);
          pins_q.din   <= cur_q.wdata;
          state_q      <= FPDC_S_COL;
        end
        FPDC_S_COL: begin
          if (pins_q.addr != cur_q.col || pins_q.ras_n) begin
            pins_q.addr <= cur_q.col;
          end else begin
            // Column latched on falling column strobe
            pins_q.cas_n <= 1'b0;
            state_q      <= (cur_q.cmd == fpdc_pkg::FPDC_CMD_WRITE) ? FPDC_S_PRE : FPDC_S_SAMPLE;
          end
        end
        FPDC_S_SAMPLE: begin
          // Data valid long after access time; act once the synced bit is pushed
          if (buf_push) begin
            if (cur_q.cmd == fpdc_pkg::FPDC_CMD_RMW) begin
              pins_q.we_n <= 1'b0;
              state_q     <= FPDC_S_WR;
            end else begin
              pins_q.cas_n <= 1'b1;
              state_q      <= FPDC_S_IDLE;
            end
          end
        end
        FPDC_S_WR: begin
          pins_q.cas_n <= 1'b1;
          pins_q.we_n  <= 1'b1;
          state_q      <= FPDC_S_IDLE;
        end
        FPDC_S_PRE: begin
          // Release strobes, keep page open after writes
          pins_q.cas_n <= 1'b1;
          pins_q.we_n  <= 1'b1;
          if (pins_q.cas_n || !open_q) begin
            if (!open_q || !init_done_o || ref_due_q) begin
              pins_q.ras_n <= 1'b1;
              open_q       <= 1'b0;
              if (!init_done_o || ref_due_q) begin
                state_q <= USE_CBR ? FPDC_S_CBR1 : FPDC_S_ROR;
              end else begin
                state_q <= FPDC_S_IDLE;
              end
            end else begin
              state_q <= FPDC_S_IDLE;
            end
          end
        end
        FPDC_S_CBR1: begin
          // Column strobe first, write select high
          pins_q.cas_n <= 1'b0;
          pins_q.we_n  <= 1'b1;
          state_q      <= FPDC_S_CBR2;
        end
        FPDC_S_CBR2: begin
          pins_q.ras_n <= ~pins_q.ras_n;
          if (!pins_q.ras_n) begin
            pins_q.cas_n <= 1'b1;
            state_q      <= FPDC_S_IDLE;
          end
        end
        FPDC_S_ROR: begin
          // Row-only refresh, column strobe stays high
          pins_q.addr  <= {1'b0, ref_row_q};
          pins_q.ras_n <= 1'b0;
          state_q      <= FPDC_S_PRE;
        end
        default: state_q <= FPDC_S_IDLE;
      endcase
    end
  end

  // Column strobe never leads row strobe outside refresh
  property p_cas_order;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(pins_q.cas_n) && state_q != FPDC_S_CBR2 |-> !pins_q.ras_n;
  endproperty
  a_cas_order: assert property (p_cas_order) else $error("cas fell with ras high");

  // Refresh owed is served in bounded time
  property p_ref_served;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(ref_due_q) && init_done_o |-> ##[1:40] !ref_due_q;
  endproperty
  a_ref_served: assert property (p_ref_served) else $error("refresh not issued");

  // No access on the pins before eight init refreshes
  property p_init_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(pins_q.cas_n) && !pins_q.ras_n |-> init_cnt_q == 4'(`FPDC_INIT_CYCLES);
  endproperty
  a_init_gate: assert property (p_init_gate) else $error("access before init");

  // Early write: write select low before column strobe falls
  property p_early_wr;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(pins_q.cas_n) && cur_q.cmd == fpdc_pkg::FPDC_CMD_WRITE && state_q == FPDC_S_PRE |-> !pins_q.we_n;
  endproperty
  a_early_wr: assert property (p_early_wr) else $error("late write select");

  // Modify-write lowers write select after sample
  property p_rmw;
    @(posedge clk_i) disable iff (!rstn_i)
      state_q == FPDC_S_WR |-> !pins_q.we_n && !pins_q.cas_n ##1 pins_q.cas_n;
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw sequence wrong");

  // Refresh with column first keeps write select high
  property p_cbr_we;
    @(posedge clk_i) disable iff (!rstn_i)
      state_q == FPDC_S_CBR2 |-> pins_q.we_n && !pins_q.cas_n;
  endproperty
  a_cbr_we: assert property (p_cbr_we) else $error("cbr write select low");

  // Row strobe idle during power-up pause
  property p_pwrup;
    @(posedge clk_i) disable iff (!rstn_i)
      state_q == FPDC_S_PWRUP |-> ##1 pins_q.ras_n;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("ras active in pause");

  // Read pushes one word into buffer
  property p_read_push;
    @(posedge clk_i) disable iff (!rstn_i)
      buf_push |-> ##1 rd_valid_o;
  endproperty
  a_read_push: assert property (p_read_push) else $error("read data lost");
endmodule : fpdc_ctrl
`default_nettype wire

// *** sim/fpdc_dram_model.sv ***
// Behavioural model of the 4M x 1 page-mode memory
`timescale 1ns/1ns
`default_nettype none
module fpdc_dram_model #(
  parameter int unsigned PAUSE_NS = 450  // Pause before init cycles count
) (
  // Power and pins
  input  wire logic                 rstn_i,
  input  wire fpdc_pkg::fpdc_pins_t pins_i,
  // Data out and tallies
  output logic                      dout_o,
  output int unsigned               refs_o,
  output int unsigned               errs_o
);
  logic        mem_q [logic [21:0]];  // Sparse 4194304-bit store
  logic [10:0] row_q;                 // Latched row
  logic [10:0] col_q;                 // Latched column
  logic [9:0]  ctr_q;                 // Internal refresh row counter
  logic        drv_q;                 // Output driven
  logic        rd_q;                  // Bit read at column fall
  int unsigned init_n;                // Init cycles after the pause
  realtime     up_t;                  // Power-up moment
  // Open output shows the inverse, so a stale bit cannot pass
  assign dout_o = drv_q ? rd_q : ~rd_q;
  initial begin
    refs_o = 0;
    errs_o = 0;
    drv_q  = 1'b0;
    rd_q   = 1'b0;
    ctr_q  = '0;
    init_n = 0;
    up_t   = 0;
  end
  // Power-up restarts pause and init tally
  always @(posedge rstn_i) begin
    up_t   = $realtime;
    init_n = 0;
  end
  // Row fall: refresh, from the counter when column leads
  always @(negedge pins_i.ras_n) begin
    refs_o++;
    if ($realtime - up_t >= PAUSE_NS) init_n++;
    if (pins_i.cas_n === 1'b0) begin
      ctr_q++;
      if (pins_i.we_n !== 1'b1) errs_o++;
    end else row_q = pins_i.addr;
  end
  // Column fall: access within the open row
  always @(negedge pins_i.cas_n) if (pins_i.ras_n === 1'b0) begin
    col_q = pins_i.addr;
    if (init_n < 8) errs_o++;
    rd_q = mem_q.exists({row_q, col_q}) ? mem_q[{row_q, col_q}] : 1'b0;
    drv_q = pins_i.we_n;
    if (pins_i.we_n === 1'b0) mem_q[{row_q, col_q}] = pins_i.din;
  end
  // Late write select keeps the old bit out, stores the new one
  always @(negedge pins_i.we_n)
    if (pins_i.ras_n === 1'b0 && pins_i.cas_n === 1'b0) mem_q[{row_q, col_q}] = pins_i.din;
  // Any strobe release opens the output
  always @(posedge pins_i.cas_n or posedge pins_i.ras_n) drv_q = 1'b0;
endmodule : fpdc_dram_model
`default_nettype wire

// *** sim/test_fast_page_dram_1bit_array.sv ***
// Self-checking bench for the page-mode memory controller
`timescale 1ns/1ns
`default_nettype none
module test_fast_page_dram_1bit_array;
  localparam int unsigned PWR = 10;  // Short power-up pause
  localparam int unsigned GAP = 50;  // Short refresh spacing
  logic                 clk_i, rstn_i, req_valid_i, rd_ready_i, stall;
  fpdc_pkg::fpdc_req_t  req_i;
  logic                 req_ready_o, rd_data_o, rd_valid_o, init_done_o, mem_dout_i;
  fpdc_pkg::fpdc_pins_t mem_o;
  int unsigned          refs, errs, bad_count, compares, base, i;
  int                   seed, r0, r1;
  logic                 exp_q [$];             // Expected read bits
  logic                 ref_m [logic [21:0]];  // Reference contents
  logic [10:0]          cols [4];              // Page columns
  fpdc_ctrl #(.PWRUP_CYC(PWR), .REF_GAP(GAP), .USE_CBR(1'b1)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .unused_dummy_o(), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .init_done_o(init_done_o), .mem_o(mem_o), .mem_dout_i(mem_dout_i));
  fpdc_dram_model #(.PAUSE_NS((PWR - 1) * 50)) model_u (
    .rstn_i(rstn_i), .pins_i(mem_o), .dout_o(mem_dout_i), .refs_o(refs), .errs_o(errs));
  // Clock at 50 ns
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run
  task close_out;
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // One request; expectation noted at the take
  task op(input fpdc_pkg::fpdc_cmd_t c, input logic [10:0] r, input logic [10:0] k, input logic w);
    @(negedge clk_i);
    req_i = '{c, r, k, w};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1) @(negedge clk_i);
    if (c != fpdc_pkg::FPDC_CMD_WRITE) exp_q.push_back(ref_m.exists({r, k}) ? ref_m[{r, k}] : 1'b0);
    if (c != fpdc_pkg::FPDC_CMD_READ) ref_m[{r, k}] = w;
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask : op
  // Reset pulse and wait for init
  task do_reset;
    @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check({mem_o.ras_n, mem_o.cas_n, mem_o.we_n}, 3'h7);
    check(req_ready_o, 1'b0);
    base = refs;
    rstn_i = 1'b1;
    while (init_done_o !== 1'b1) @(negedge clk_i);
    check(refs - base >= 8, 1'b1);
  endtask : do_reset
  // Receiver: random stalls, oldest note compared at each handshake
  initial forever begin
    @(negedge clk_i);
    r1 = $random(seed);
    rd_ready_i = stall ? 1'b0 : r1[0];
    if (rstn_i === 1'b1 && rd_valid_o === 1'b1 && rd_ready_i) begin
      if (exp_q.size() == 0) check(rd_data_o, 32'hbad);
      else check(rd_data_o, exp_q.pop_front());
    end
  end
  // Hang guard
  initial begin
    #(60000 * 50);
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    seed = 17;
    stall = 1'b0;
    bad_count = 0;
    compares = 0;
    rstn_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    rd_ready_i = 1'b0;
    do_reset();
    // Corner cells, write then read
    op(fpdc_pkg::FPDC_CMD_WRITE, 11'h7ff, 11'h7ff, 1'b1);
    op(fpdc_pkg::FPDC_CMD_READ, 11'h7ff, 11'h7ff, 1'b0);
    op(fpdc_pkg::FPDC_CMD_WRITE, 11'h000, 11'h000, 1'b1);
    // Page: several columns of one row, read back reversed
    for (i = 0; i < 4; i++) begin
      r0 = $random(seed);
      cols[i] = r0[10:0];
      op(fpdc_pkg::FPDC_CMD_WRITE, 11'h005, cols[i], r0[11]);
    end
    for (i = 4; i > 0; i--) op(fpdc_pkg::FPDC_CMD_READ, 11'h005, cols[i - 1], 1'b0);
    // Modify: old bit returned, new bit stored
    op(fpdc_pkg::FPDC_CMD_RMW, 11'h000, 11'h000, 1'b0);
    op(fpdc_pkg::FPDC_CMD_READ, 11'h000, 11'h000, 1'b0);
    // Receiver stalls: buffer fills, then refuses
    while (exp_q.size() != 0) @(negedge clk_i);
    stall = 1'b1;
    op(fpdc_pkg::FPDC_CMD_READ, 11'h7ff, 11'h7ff, 1'b0);
    op(fpdc_pkg::FPDC_CMD_READ, 11'h005, cols[0], 1'b0);
    repeat (12) @(negedge clk_i);
    check(req_ready_o, 1'b0);
    check(rd_valid_o, 1'b1);
    stall = 1'b0;
    op(fpdc_pkg::FPDC_CMD_READ, 11'h005, cols[1], 1'b0);
    // Random traffic across refreshes
    for (i = 0; i < 150; i++) begin
      r0 = $random(seed);
      op(fpdc_pkg::fpdc_cmd_t'(r0[1:0] % 3), {9'h000, r0[3:2]}, r0[14:4], r0[15]);
    end
    // Idle: refreshes keep their pace
    base = refs;
    repeat (600) @(negedge clk_i);
    check(refs - base >= 600 / GAP - 1, 1'b1);
    // Reset mid-run, then re-init and carry on
    do_reset();
    op(fpdc_pkg::FPDC_CMD_READ, 11'h005, cols[2], 1'b0);
    repeat (100) if (exp_q.size() != 0) @(negedge clk_i);
    check(exp_q.size(), 0);
    check(errs, 0);
    close_out();
  end
endmodule : test_fast_page_dram_1bit_array
`default_nettype wire
